// *** shared/flash_defines.svh ***
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH
// Overview of operation
// [R1] Hold reset pin at high identification voltage to run temporary unprotect.
// [R2] During temporary unprotect, protected groups accept program and erase.
// [R3] Removing the high voltage re-protects every previously protected group.
// [R4] Write-protect low keeps the two outermost boot sectors protected meanwhile.
// [R5] A separate 256-byte secure region holds a permanent serial number.
// [R6] Data bit 7 lock indicator: 1 factory locked, 0 customer lockable.
// [R7] After the enter sequence, boot-sector reads come from the secure region.
// [R8] Secure mode lasts until exit sequence; power-up or hardware reset ends it.
// [R9] A factory locked part refuses any change to the secure region.
// [R10] Bottom boot: 16-byte serial number at byte 00000h-0000Fh, word 00000h-00007h.
// [R11] Top boot: serial number in sector 34 from byte 1FFF0h or word FFF8h.
// [R12] Unlock bypass is not available while programming the secure region.
// [R13] Lock: enter sequence, then protect using group address pattern 1Ah.
// [R14] A protected secure region can never be unprotected or modified.
// [R15] After locking, issue the exit sequence before any other array access.
// [R16] Query mode entered by 98h to 55h word mode or AAh byte mode.
// [R17] Word-mode query reads drive address bits A7 and above to zero.
// [R18] Only the reset command leaves query mode; here a hardware reset (OP_HWRST) also clears it.
// [R19] Query entered from autoselect returns to autoselect on reset command.
// [R20] Query string 0051h 0052h 0059h at word 10h-12h, byte 20h 22h 24h.
// [R21] Command set 0002h at 13h, 0000h at 14h, extended table 0040h at 15h.
// [R22] Words 17h to 1Ah read 0000h: no alternate command set or table.
// [R23] Query entered from array read returns to array read on reset.

`define CLK_NS       10
`define STROBE_NS    70
`define STROBE_CYC   ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)

`define REG_CTRL     5'h00
`define REG_ADDR     5'h04
`define REG_WDATA    5'h08
`define REG_STATUS   5'h0c
`define REG_RDATA    5'h10

`define CTRL_OP      2:0
`define CTRL_GO      3
`define CTRL_BYTE    4
`define CTRL_HV      5
`define CTRL_WP      6
`define STAT_ERR     4

`define OP_READ      3'h0
`define OP_WRITE     3'h1
`define OP_SEC_IN    3'h2
`define OP_SEC_OUT   3'h3
`define OP_QUERY     3'h4
`define OP_RESET     3'h5
`define OP_LOCK      3'h6
`define OP_HWRST     3'h7

`define UNL1_W       20'h00555
`define UNL2_W       20'h002aa
`define UNL1_B       20'h00aaa
`define UNL2_B       20'h00555
`define QRY_W        20'h00055
`define QRY_B        20'h000aa
`define QRY_MASK     19:7
`define SEC_GROUP    8'h1a
`define CMD_UNL1     16'h00aa
`define CMD_UNL2     16'h0055
`define CMD_SEC_IN   16'h0088
`define CMD_SEC_OUT  16'h0090
`define CMD_SEC_OUT2 16'h0000
`define CMD_QUERY    16'h0098
`define CMD_RESET    16'h00f0
`define CMD_PROG     16'h00a0

`define FL_RST       45'h000000000f6
`define RESP_OK      2'h0
`define RESP_ERR     2'h2
`endif

// *** shared/flash_pkg.sv ***
package flash_pkg;
   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] dq;
      logic        dq_oe;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        reset_n;
      logic        hv_en;
      logic        wp_n;
      logic        byte_n;
      logic        spare;
   } flash_out_t;

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} bus_state_t;
endpackage : flash_pkg

// *** hdl/flash_mode_ctrl.sv ***
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "flash_defines.svh"
module flash_mode_ctrl #(
   parameter int PULSE_C = `STROBE_CYC
) (
   // Clock, reset, enable
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   // AXI4-Lite write
   input  wire logic [4:0]           awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   // AXI4-Lite read
   input  wire logic [4:0]           araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready,
   // Flash pins
   output flash_pkg::flash_out_t     fl,
   input  wire logic [15:0]          dq_in
);

   flash_pkg::bus_state_t st, next_st;
   flash_pkg::flash_out_t next_fl;
   logic [7:0]  cnt, next_cnt;
   logic [1:0]  step, next_step;
   logic [2:0]  op, next_op;
   logic        bm, next_bm, hv, next_hv, wpn, next_wpn;
   logic [19:0] addr_r, next_addr;
   logic [15:0] wdata_r, next_wdata;
   logic [15:0] rd_r, next_rd;
   logic        qry, next_qry, sec, next_sec, pend, next_pend, err, next_err;
   logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [15:0] dq_s1, dq_s2;
   logic [36:0] c;
   logic        wr, rd, last, is_cmd, ok_w;
   logic [4:0]  status;

   function automatic logic [36:0] cyc(input logic [2:0] o, input logic [1:0] s, input logic b);
      logic [19:0] u1;
      logic [19:0] u2;
      u1 = b ? `UNL1_B : `UNL1_W;
      u2 = b ? `UNL2_B : `UNL2_W;
      case (o)
         `OP_SEC_IN, `OP_SEC_OUT:
            case (s)
               2'h0: cyc = {1'b0, u1, `CMD_UNL1};
               2'h1: cyc = {1'b0, u2, `CMD_UNL2};
               2'h2: cyc = {o == `OP_SEC_IN, u1, (o == `OP_SEC_IN) ? `CMD_SEC_IN : `CMD_SEC_OUT};
               default: cyc = {1'b1, 20'h00000, `CMD_SEC_OUT2};
            endcase
         `OP_QUERY: cyc = {1'b1, b ? `QRY_B : `QRY_W, `CMD_QUERY}; // [R16]
         default: cyc = {1'b1, 20'h00000, `CMD_RESET}; // [R18]
      endcase
   endfunction : cyc

   assign status = {err, pend, sec, qry, st != flash_pkg::ST_IDLE};

   always_comb
   begin
      next_st = st;
      next_fl = fl;
      next_cnt = cnt;
      next_step = step;
      next_op = op;
      next_bm = bm;
      next_hv = hv;
      next_wpn = wpn;
      next_addr = addr_r;
      next_wdata = wdata_r;
      next_rd = rd_r;
      next_qry = qry;
      next_sec = sec;
      next_pend = pend;
      next_err = err;
      next_bresp = bresp;
      next_bvalid = bvalid && !bready;
      next_rresp = rresp;
      next_rdata = rdata;
      next_rvalid = rvalid && !rready;
      next_awready = !awready && awvalid && wvalid && !bvalid;
      next_wready = !wready && awvalid && wvalid && !bvalid;
      next_arready = !arready && arvalid && !rvalid;
      wr = awready && awvalid && wready && wvalid;
      rd = arready && arvalid;
      ok_w = (wstrb == 4'hf);
      is_cmd = (op == `OP_SEC_IN) || (op == `OP_SEC_OUT) || (op == `OP_QUERY) || (op == `OP_RESET);
      c = cyc(op, step, bm);
      last = is_cmd ? c[36] : 1'b1;

      // Register writes; partial strobes are refused whole
      if (wr)
      begin
         next_bvalid = 1'b1;
         next_bresp = `RESP_OK;
         if (!ok_w)
            next_bresp = `RESP_ERR;
         else if (awaddr == `REG_CTRL)
         begin
            next_bm = wdata[`CTRL_BYTE];
            next_hv = wdata[`CTRL_HV]; // [R1]
            next_wpn = wdata[`CTRL_WP];
            if (st == flash_pkg::ST_IDLE)
               next_op = wdata[`CTRL_OP];
            if (wdata[`CTRL_GO])
            begin
               if (st != flash_pkg::ST_IDLE)
                  next_err = 1'b1;
               else if (pend && (wdata[`CTRL_OP] == `OP_READ || wdata[`CTRL_OP] == `OP_WRITE))
                  next_err = 1'b1; // [R15]
               else if (!sec && wdata[`CTRL_OP] == `OP_LOCK)
                  next_err = 1'b1; // [R13]
               else
               begin
                  next_step = 2'h0;
                  next_st = flash_pkg::ST_SETUP;
               end
            end
         end
         else if (awaddr == `REG_ADDR)
            next_addr = wdata[19:0];
         else if (awaddr == `REG_WDATA)
            next_wdata = wdata[15:0];
         else if (awaddr == `REG_STATUS)
         begin
            // A refusal in the same cycle outranks the clear
            if (wdata[`STAT_ERR] && next_err == err)
               next_err = 1'b0;
         end
         else if (awaddr != `REG_RDATA)
            next_bresp = `RESP_ERR;
      end

      if (rd)
      begin
         next_rvalid = 1'b1;
         next_rresp = `RESP_OK;
         case (araddr)
            `REG_CTRL:   next_rdata = {25'h0000000, wpn, hv, bm, 1'b0, op};
            `REG_ADDR:   next_rdata = {12'h000, addr_r};
            `REG_WDATA:  next_rdata = {16'h0000, wdata_r};
            `REG_STATUS: next_rdata = {27'h0000000, status};
            `REG_RDATA:  next_rdata = {16'h0000, rd_r};
            default:
            begin
               next_rdata = 32'h00000000;
               next_rresp = `RESP_ERR;
            end
         endcase
      end

      next_fl.hv_en = hv; // [R1]
      next_fl.wp_n = wpn;
      next_fl.byte_n = !bm;

      case (st)
         flash_pkg::ST_IDLE:
         begin
            next_fl.ce_n = 1'b1;
            next_fl.dq_oe = 1'b0;
         end
         flash_pkg::ST_SETUP:
         begin
            next_fl.ce_n = (op == `OP_HWRST);
            next_fl.dq_oe = (op != `OP_READ) && (op != `OP_HWRST);
            next_fl.addr = addr_r;
            next_fl.dq = wdata_r;
            if (is_cmd)
            begin
               next_fl.addr = c[35:16]; // [R16]
               next_fl.dq = c[15:0];
            end
            else if (op == `OP_LOCK)
               next_fl.addr = {addr_r[19:8], `SEC_GROUP}; // [R13]
            if (qry && !bm && op == `OP_READ)
               next_fl.addr[`QRY_MASK] = '0; // [R17]
            next_cnt = 8'(PULSE_C);
            next_st = flash_pkg::ST_STROBE;
         end
         flash_pkg::ST_STROBE:
         begin
            if (cnt == 8'h00)
            begin
               next_fl.we_n = 1'b1;
               next_fl.oe_n = 1'b1;
               next_fl.reset_n = 1'b1;
               if (op == `OP_READ)
                  next_rd = dq_s2;
               next_st = flash_pkg::ST_HOLD;
            end
            else
            begin
               next_cnt = cnt - 8'h01;
               next_fl.oe_n = (op != `OP_READ);
               next_fl.reset_n = (op != `OP_HWRST);
               next_fl.we_n = (op == `OP_READ) || (op == `OP_HWRST);
            end
         end
         flash_pkg::ST_HOLD:
         begin
            next_fl.ce_n = 1'b1;
            next_fl.dq_oe = 1'b0;
            if (last)
            begin
               next_st = flash_pkg::ST_IDLE;
               case (op)
                  `OP_QUERY:   next_qry = 1'b1; // [R16]
                  `OP_RESET:   next_qry = 1'b0; // [R18] [R19] [R23]
                  `OP_SEC_IN:  next_sec = 1'b1;
                  `OP_LOCK:    next_pend = 1'b1; // [R15]
                  `OP_SEC_OUT:
                  begin
                     next_sec = 1'b0;
                     next_pend = 1'b0; // [R15]
                  end
                  `OP_HWRST:
                  begin
                     next_sec = 1'b0; // [R8]
                     next_qry = 1'b0;
                  end
                  default: next_qry = qry;
               endcase
            end
            else
            begin
               next_step = step + 2'h1;
               next_st = flash_pkg::ST_SETUP;
            end
         end
         default: next_st = flash_pkg::ST_IDLE;
      endcase
   end

   // Data pins cross from the flash, so they are synchronised before sampling
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= flash_pkg::ST_IDLE;
         fl <= `FL_RST;
         cnt <= '0;
         step <= '0;
         op <= `OP_READ;
         bm <= 1'b0;
         hv <= 1'b0;
         wpn <= 1'b1;
         addr_r <= '0;
         wdata_r <= '0;
         rd_r <= '0;
         qry <= 1'b0;
         sec <= 1'b0;
         pend <= 1'b0;
         err <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OK;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rresp <= `RESP_OK;
         rdata <= '0;
         dq_s1 <= '0;
         dq_s2 <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
         fl <= next_fl;
         cnt <= next_cnt;
         step <= next_step;
         op <= next_op;
         bm <= next_bm;
         hv <= next_hv;
         wpn <= next_wpn;
         addr_r <= next_addr;
         wdata_r <= next_wdata;
         rd_r <= next_rd;
         qry <= next_qry;
         sec <= next_sec;
         pend <= next_pend;
         err <= next_err;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   a_hv_follows_ctrl: // [R1]
      assert property (##1 $changed(hv) |-> ##1 fl.hv_en == hv)
      else $error("high voltage enable lags control");
   a_query_cmd: // [R16]
      assert property (!fl.we_n && op == `OP_QUERY |-> fl.dq == `CMD_QUERY && fl.addr == (bm ? `QRY_B : `QRY_W))
      else $error("query command misdriven");
   a_query_addr_mask: // [R17]
      assert property (qry && !bm && !fl.oe_n |-> fl.addr[`QRY_MASK] == '0)
      else $error("query read upper address not zero");
   a_reset_ends_query: // [R18]
      assert property (st == flash_pkg::ST_HOLD && op == `OP_RESET |=> !qry && st == flash_pkg::ST_IDLE)
      else $error("reset command left query mode set");
   a_lock_group_addr: // [R13]
      assert property (!fl.we_n && op == `OP_LOCK |-> fl.addr[7:0] == `SEC_GROUP && sec)
      else $error("lock write used wrong group address");
   a_no_array_pending: // [R15]
      assert property (pend && st == flash_pkg::ST_STROBE |-> op != `OP_READ && op != `OP_WRITE)
      else $error("array access before secure exit");
   a_strobe_len: // [R16]
      assert property ($fell(fl.we_n) |-> !fl.we_n [*7] ##1 fl.we_n)
      else $error("write strobe length wrong");
   a_exit_clears_sec: // [R15]
      assert property (st == flash_pkg::ST_HOLD && op == `OP_SEC_OUT && step == 2'h3 |=> !sec && !pend)
      else $error("secure exit left mode set");
   a_strobes_exclusive: // [R16]
      assert property (!(fl.we_n == 1'b0 && fl.oe_n == 1'b0) && (fl.we_n || fl.dq_oe))
      else $error("strobe overlap or undriven data");
endmodule : flash_mode_ctrl

// *** sim/flash_model.sv ***
`timescale 1ns/10ps
`include "flash_defines.svh"
module flash_model #(
   parameter logic LOCKED0 = 1'b0
) (
   // Host side pins
   input  wire flash_pkg::flash_out_t fl,
   output logic [15:0]                dq_out
);
   logic [15:0] mem  [int];
   logic [15:0] sn   [0:127];
   logic [15:0] qt   [0:10] = '{16'h51, 16'h52, 16'h59, 16'h2, 16'h0, 16'h40, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   logic [2:0]  step = 3'h0;
   logic        sec  = 1'b0;
   logic        qry  = 1'b0;
   logic        lock = LOCKED0; // factory-locked parts start locked for good
   logic [15:0] last = 16'h0;
   logic [19:0] u1, u2;
   initial
      foreach (sn[i]) sn[i] = 16'h5e00 + 16'(i);
   function automatic logic [15:0] rd(input logic [19:0] a);
      logic [19:0] w;
      w = fl.byte_n ? a : a >> 1;
      if (qry)
         return (w >= 20'h10 && w <= 20'h1a) ? qt[w - 20'h10] : 16'h0;
      // Bottom boot layout only; a top-boot part would map from word FFF8h
      if (sec && w < 20'h80)
         return sn[w[6:0]];
      return mem.exists(w) ? mem[w] : 16'hffff;
   endfunction : rd
   function automatic logic prot(input logic [19:0] a);
      if (fl.wp_n === 1'b0 && a[19:14] == 6'h3f)
         return 1'b1;
      return a[19:16] == 4'hf && fl.hv_en !== 1'b1;
   endfunction : prot
   // Hardware reset drops every mode
   always @(negedge fl.reset_n)
   begin
      sec = 1'b0;
      qry = 1'b0;
      step = 3'h0;
   end
   always @(posedge fl.we_n)
      if (fl.ce_n === 1'b0)
      begin
         u1 = fl.byte_n ? `UNL1_W : `UNL1_B;
         u2 = fl.byte_n ? `UNL2_W : `UNL2_B;
         if (fl.dq == `CMD_QUERY && fl.addr == (fl.byte_n ? `QRY_W : `QRY_B))
            qry = 1'b1;
         else if (qry)
            qry = fl.dq != `CMD_RESET;
         else if (sec && step == 3'h0 && fl.addr[7:0] == `SEC_GROUP)
            lock = 1'b1;
         else if (step == 3'h0)
            step = (fl.dq == `CMD_UNL1 && fl.addr == u1) ? 3'h1 : 3'h0;
         else if (step == 3'h1)
            step = (fl.dq == `CMD_UNL2 && fl.addr == u2) ? 3'h2 : 3'h0;
         else if (step == 3'h2)
         begin
            if (fl.addr == u1 && fl.dq == `CMD_SEC_IN)
               sec = 1'b1;
            // Only the full unlocked program sequence reaches the data write
            step = fl.addr != u1 ? 3'h0 : fl.dq == `CMD_PROG ? 3'h4 : fl.dq == `CMD_SEC_OUT ? 3'h3 : 3'h0;
         end
         else if (step == 3'h3)
         begin
            if (fl.dq == `CMD_SEC_OUT2)
               sec = 1'b0;
            step = 3'h0;
         end
         else
         begin
            if (sec && !lock && fl.addr < 20'h80)
               sn[fl.addr[6:0]] = fl.dq;
            else if (!sec && !prot(fl.addr))
               mem[fl.addr] = fl.dq;
            step = 3'h0;
         end
      end
   // Unselected bus shows the inverse of the last driven word, not a stale copy
   always @(fl or qry or sec)
      if (fl.ce_n === 1'b0 && fl.oe_n === 1'b0)
      begin
         dq_out = rd(fl.addr);
         last = dq_out;
      end
      else
         dq_out = ~last;
endmodule : flash_model

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`include "flash_defines.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [4:0]            awaddr, araddr;
   logic [31:0]           wdata, rdata, rv;
   logic [3:0]            wstrb;
   logic [1:0]            bresp, rresp, resp;
   logic [15:0]           dq_in;
   logic [2:0]            mode;
   logic [15:0]           qt [0:10] = '{16'h51, 16'h52, 16'h59, 16'h2, 16'h0, 16'h40, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   flash_pkg::flash_out_t fl;
   int                    n_fail = 0;
   int                    total_checks = 0;
   flash_mode_ctrl flash_mode_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .fl(fl), .dq_in(dq_in));
   flash_model flash_model_inst (.fl(fl), .dq_out(dq_in));
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      while (bvalid !== 1'b1) @(posedge aclk);
      resp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr
   task automatic axi_rd(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rv = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   task automatic op(input logic [2:0] o);
      axi_wr(`REG_CTRL, {25'h0, mode, 1'b1, o});
      do axi_rd(`REG_STATUS); while (rv[0] !== 1'b0);
   endtask : op
   task automatic fw(input logic [19:0] a, input logic [15:0] d);
      axi_wr(`REG_ADDR, {12'h0, a});
      axi_wr(`REG_WDATA, {16'h0, d});
      op(`OP_WRITE);
   endtask : fw
   task automatic frd(input logic [19:0] a);
      axi_wr(`REG_ADDR, {12'h0, a});
      op(`OP_READ);
      axi_rd(`REG_RDATA);
   endtask : frd
   // Word-mode program sequence; the controller issues one bus cycle per op
   task automatic prog(input logic [19:0] a, input logic [15:0] d);
      fw(`UNL1_W, `CMD_UNL1);
      fw(`UNL2_W, `CMD_UNL2);
      fw(`UNL1_W, `CMD_PROG);
      fw(a, d);
   endtask : prog
   task automatic complete_run;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial
   begin
      // Tests need a few thousand cycles; this leaves ample margin
      #200us;
      n_fail++;
      complete_run();
   end
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      mode = 3'b100;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK({fl.ce_n, fl.oe_n, fl.we_n, fl.reset_n, fl.hv_en, fl.dq_oe}, 6'b111100)
      axi_rd(`REG_STATUS);
      `CHK(rv, 32'h0)
      axi_rd(5'h14);
      `CHK({resp, rv}, {`RESP_ERR, 32'h0})
      wstrb <= 4'h3;
      axi_wr(`REG_ADDR, 32'h5);
      `CHK(resp, `RESP_ERR)
      wstrb <= 4'hf;
      $display("done: registers");
      op(`OP_QUERY);
      axi_rd(`REG_STATUS);
      `CHK(rv[1], 1'b1)
      for (int i = 0; i < 11; i++)
      begin
         frd(20'h10 + 20'(i));
         `CHK(rv[15:0], qt[i])
      end
      frd(20'h90);
      `CHK(rv[15:0], 16'h0051)
      frd(20'h12);
      `CHK(rv[15:0], 16'h0059)
      op(`OP_RESET);
      frd(20'h10);
      `CHK(rv[15:0], 16'hffff)
      mode = 3'b101;
      op(`OP_QUERY);
      for (int i = 0; i < 3; i++)
      begin
         frd(20'h20 + 20'(2 * i));
         `CHK(rv[7:0], qt[i][7:0])
      end
      op(`OP_RESET);
      op(`OP_SEC_IN);
      frd(20'h2);
      `CHK(rv[7:0], 8'h01)
      op(`OP_SEC_OUT);
      frd(20'h2);
      `CHK(rv[7:0], 8'hff)
      mode = 3'b100;
      $display("done: query");
      prog(20'h0, 16'h1234);
      op(`OP_SEC_IN);
      frd(20'h0);
      `CHK(rv[15:0], 16'h5e00)
      prog(20'h1, 16'h0bad);
      frd(20'h1);
      `CHK(rv[15:0], 16'h0bad)
      op(`OP_LOCK);
      axi_rd(`REG_STATUS);
      `CHK(rv[3:2], 2'b11)
      op(`OP_SEC_OUT);
      frd(20'h0);
      `CHK(rv[15:0], 16'h1234)
      op(`OP_SEC_IN);
      prog(20'h2, 16'h0);
      frd(20'h2);
      `CHK(rv[15:0], 16'h5e02)
      op(`OP_HWRST);
      frd(20'h0);
      `CHK(rv[15:0], 16'h1234)
      op(`OP_LOCK);
      axi_rd(`REG_STATUS);
      `CHK(rv[4], 1'b1)
      axi_wr(`REG_STATUS, 32'h10);
      axi_rd(`REG_STATUS);
      `CHK(rv[4], 1'b0)
      $display("done: secure region");
      prog(20'hf0000, 16'h1111);
      frd(20'hf0000);
      `CHK(rv[15:0], 16'hffff)
      mode = 3'b110;
      axi_wr(`REG_CTRL, {25'h0, mode, 4'h0});
      `CHK(fl.hv_en, 1'b1)
      prog(20'hf0000, 16'h1111);
      frd(20'hf0000);
      `CHK(rv[15:0], 16'h1111)
      mode = 3'b010;
      prog(20'hfc000, 16'h2222);
      frd(20'hfc000);
      `CHK(rv[15:0], 16'hffff)
      mode = 3'b100;
      prog(20'hf0000, 16'h0);
      frd(20'hf0000);
      `CHK(rv[15:0], 16'h1111)
      $display("done: unprotect");
      complete_run();
   end
endmodule : tb_top
